// File: design/vsfs_params.svh
`ifndef VSFS_PARAMS_SVH
`define VSFS_PARAMS_SVH
`define VSFS_CLK_MHZ         100
`define VSFS_CFG_TIME_US     30
`define VSFS_CFG_CYCLES      (`VSFS_CFG_TIME_US * `VSFS_CLK_MHZ)
`define VSFS_OCP_TIME_US     50
`define VSFS_OCP_CYCLES      (`VSFS_OCP_TIME_US * `VSFS_CLK_MHZ)
`define VSFS_STEP_TIME_US    1
`define VSFS_STEP_CYCLES     (`VSFS_STEP_TIME_US * `VSFS_CLK_MHZ)
`define VSFS_DRIVER_ON_OUTPUT_HOLD_US    10
`define VSFS_DRIVER_ON_OUTPUT_HOLD_CYC   (`VSFS_DRIVER_ON_OUTPUT_HOLD_US * `VSFS_CLK_MHZ)
`define VSFS_DAC_W           8
`define VSFS_ARM_DAC_CODE    8'h0f
`define VSFS_OV_ABS_CODE     8'h91
`define VSFS_OV_MARGIN       8'h14
`define VSFS_UV_MARGIN       8'h0f
`define VSFS_OV_RELEASE      8'h0a
`define VSFS_VOUT_ARM_CODE   8'h0d
`endif

// File: design/vsfs_pkg.sv
package vsfs_pkg;
    typedef enum logic [1:0] {
        VSFS_PWM_LOW,
        VSFS_PWM_HIGH,
        VSFS_PWM_MID,
        VSFS_PWM_OPEN
    } vsfs_pwm_t;

    typedef enum logic [2:0] {
        VSFS_IDLE,
        VSFS_CONFIG,
        VSFS_DRV_WAIT,
        VSFS_RAMP,
        VSFS_RUN,
        VSFS_OC_LATCH,
        VSFS_OV_LATCH
    } vsfs_state_t;
endpackage

// File: design/vsfs_sequencer.sv
// Functional notes
// - In soft start a counter steps the DAC code from zero to target at a fixed rate.
// - Before configuration is done every PWM output is open with a test current applied.
// - After configuration with enable high, PWM outputs go to mid level, then driver-on rises.
// - Each phase leaves mid level on its own first PWM pulse while the DAC ramps.
// - Dropping enable returns every PWM output to mid level.
// - Current above the limit starts a latch-off timer; still present at expiry, shut down.
// - Current above the upper over-current level shuts down at once.
// - After over-current shutdown outputs stay off until supply cycle or enable toggle.
// - Current limit arms at start-up once output or DAC passes its own threshold.
// - Regulator-ready drops when output falls the under-voltage margin below DAC minus droop.
// - Output above DAC by the over-voltage margin drops ready and ramps the DAC to zero.
// - On over-voltage high sides are off and low sides on until output is near new DAC.
// - After over-voltage the protective state latches until supply cycle or enable toggle.
// - During start-up a fixed absolute over-voltage level replaces the relative one.
`include "vsfs_params.svh"

module vsfs_sequencer
    import vsfs_pkg::*;
#(
    parameter int PHASES      = 4,
    parameter int DAC_W       = `VSFS_DAC_W,
    parameter int CFG_CYCLES  = `VSFS_CFG_CYCLES,
    parameter int OCP_CYCLES  = `VSFS_OCP_CYCLES,
    parameter int STEP_CYCLES = `VSFS_STEP_CYCLES
)
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  enable_i,
    input  wire logic [DAC_W-1:0]      target_code_i,
    input  wire logic [DAC_W-1:0]      vout_code_i,
    input  wire logic [DAC_W-1:0]      droop_code_i,
    input  wire logic                  limit_threshold_current_i,
    input  wire logic                  upper_overcurrent_i,
    input  wire logic [PHASES-1:0]     pwm_request_i,
    input  wire logic                  driver_ready_i,
    output logic      [DAC_W-1:0]      dac_code_o,
    output vsfs_pwm_t [PHASES-1:0]     pwm_state_o,
    output logic                       test_current_o,
    output logic                       driver_on_output_o,
    output logic                       regulator_ready_o,
    output logic                       current_limit_stages_armed_o,
    output logic                       oc_fault_o,
    output logic                       ov_fault_o
);
    localparam int CNT_W = $clog2(OCP_CYCLES + CFG_CYCLES + STEP_CYCLES + 2);

    typedef struct packed {
        vsfs_state_t              state;
        logic [CNT_W-1:0]         timer;
        logic [CNT_W-1:0]         step;
        logic [CNT_W-1:0]         oc_timer;
        logic [DAC_W-1:0]         dac;
        vsfs_pwm_t [PHASES-1:0]   pwm;
        logic                     test_cur;
        logic                     drv_on;
        logic                     ready;
        logic                     armed;
        logic                     ov_clamp;
    } vsfs_regs_t;

    vsfs_regs_t state_reg;
    vsfs_regs_t state_next;

    function automatic vsfs_pwm_t [PHASES-1:0] vsfs_all(input vsfs_pwm_t v);
        vsfs_pwm_t [PHASES-1:0] r;
        for (int i = 0; i < PHASES; i++)
        begin
            r[i] = v;
        end
        return r;
    endfunction

    // Saturating add keeps margins from wrapping near full scale
    function automatic logic [DAC_W-1:0] vsfs_sat_add(input logic [DAC_W-1:0] a,
                                                      input logic [DAC_W-1:0] b);
        logic [DAC_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[DAC_W] ? {DAC_W{1'b1}} : s[DAC_W-1:0];
    endfunction

    function automatic logic [DAC_W-1:0] vsfs_sat_sub(input logic [DAC_W-1:0] a,
                                                      input logic [DAC_W-1:0] b);
        return (a > b) ? a - b : '0;
    endfunction

    logic [DAC_W-1:0] uv_level;
    logic [DAC_W-1:0] ov_level;
    logic             ov_hit;
    logic             uv_hit;
    logic             oc_trip;

    always_comb
    begin
        uv_level = vsfs_sat_sub(vsfs_sat_sub(state_reg.dac, droop_code_i), `VSFS_UV_MARGIN);
        // Start-up uses an absolute level so pre-charged outputs do not trip
        ov_level = (state_reg.state == VSFS_RUN) ?
                   vsfs_sat_add(state_reg.dac, `VSFS_OV_MARGIN) : `VSFS_OV_ABS_CODE;
        ov_hit   = (vout_code_i > ov_level);
        uv_hit   = (vout_code_i < uv_level);
        oc_trip  = state_reg.armed &&
                   (upper_overcurrent_i ||
                    (limit_threshold_current_i &&
                     state_reg.oc_timer >= CNT_W'(OCP_CYCLES - 1)));
    end

    always_comb
    begin
        state_next = state_reg;
        if (!enable_i)
        begin
            // Apart from reset, disabling is the only way out of a latched fault
            state_next.state    = VSFS_IDLE;
            state_next.pwm      = vsfs_all(VSFS_PWM_MID);
            state_next.drv_on   = 1'b0;
            state_next.ready    = 1'b0;
            state_next.armed    = 1'b0;
            state_next.ov_clamp = 1'b0;
            state_next.test_cur = 1'b0;
            state_next.dac      = '0;
            state_next.timer    = '0;
            state_next.step     = '0;
            state_next.oc_timer = '0;
        end
        else
        begin
            unique case (state_reg.state)
                VSFS_IDLE:
                begin
                    state_next.state    = VSFS_CONFIG;
                    state_next.pwm      = vsfs_all(VSFS_PWM_OPEN);
                    state_next.test_cur = 1'b1;
                    state_next.timer    = '0;
                end
                VSFS_CONFIG:
                begin
                    state_next.timer = state_reg.timer + 1'b1;
                    if (state_reg.timer >= CNT_W'(CFG_CYCLES - 1))
                    begin
                        state_next.state    = VSFS_DRV_WAIT;
                        state_next.test_cur = 1'b0;
                        state_next.pwm      = vsfs_all(VSFS_PWM_MID);
                    end
                end
                VSFS_DRV_WAIT:
                begin
                    // Mid level is already out at least one cycle before driver-on
                    if (driver_ready_i)
                    begin
                        state_next.drv_on = 1'b1;
                        state_next.state  = VSFS_RAMP;
                        state_next.step   = '0;
                    end
                end
                VSFS_RAMP, VSFS_RUN:
                begin
                    if (!driver_ready_i)
                    begin
                        // Driver undervoltage restarts the enable sequence
                        state_next.state  = VSFS_DRV_WAIT;
                        state_next.drv_on = 1'b0;
                        state_next.ready  = 1'b0;
                        state_next.pwm    = vsfs_all(VSFS_PWM_MID);
                    end
                    else
                    begin
                        if (state_reg.state == VSFS_RAMP)
                        begin
                            state_next.step = state_reg.step + 1'b1;
                            if (state_reg.step >= CNT_W'(STEP_CYCLES - 1))
                            begin
                                state_next.step = '0;
                                if (state_reg.dac < target_code_i)
                                    state_next.dac = state_reg.dac + 1'b1;
                            end
                            if (state_reg.dac >= target_code_i)
                            begin
                                state_next.state = VSFS_RUN;
                                state_next.ready = 1'b1;
                            end
                            if (vout_code_i > `VSFS_VOUT_ARM_CODE ||
                                state_reg.dac > `VSFS_ARM_DAC_CODE)
                                state_next.armed = 1'b1;
                        end
                        else
                        begin
                            state_next.dac = target_code_i;
                            if (uv_hit)
                                state_next.ready = 1'b0;
                        end
                        for (int i = 0; i < PHASES; i++)
                        begin
                            if (state_reg.pwm[i] != VSFS_PWM_MID || pwm_request_i[i])
                                state_next.pwm[i] = pwm_request_i[i] ?
                                                    VSFS_PWM_HIGH : VSFS_PWM_LOW;
                        end
                        if (state_reg.armed && limit_threshold_current_i)
                            state_next.oc_timer = state_reg.oc_timer + 1'b1;
                        else
                            state_next.oc_timer = '0;
                        if (oc_trip)
                        begin
                            state_next.state  = VSFS_OC_LATCH;
                            state_next.pwm    = vsfs_all(VSFS_PWM_MID);
                            state_next.drv_on = 1'b0;
                            state_next.ready  = 1'b0;
                        end
                        else if (ov_hit)
                        begin
                            state_next.state    = VSFS_OV_LATCH;
                            state_next.ready    = 1'b0;
                            state_next.ov_clamp = 1'b1;
                            state_next.pwm      = vsfs_all(VSFS_PWM_LOW);
                        end
                    end
                end
                VSFS_OC_LATCH:
                begin
                    state_next.pwm = vsfs_all(VSFS_PWM_MID);
                end
                VSFS_OV_LATCH:
                begin
                    state_next.ready = 1'b0;
                    state_next.step  = state_reg.step + 1'b1;
                    if (state_reg.step >= CNT_W'(STEP_CYCLES - 1))
                    begin
                        state_next.step = '0;
                        if (state_reg.dac != '0)
                            state_next.dac = state_reg.dac - 1'b1;
                    end
                    if (state_reg.ov_clamp &&
                        vout_code_i <= vsfs_sat_add(state_reg.dac, `VSFS_OV_RELEASE))
                    begin
                        state_next.ov_clamp = 1'b0;
                        state_next.pwm      = vsfs_all(VSFS_PWM_MID);
                    end
                    else if (state_reg.ov_clamp)
                        state_next.pwm = vsfs_all(VSFS_PWM_LOW);
                end
                default:
                begin
                    state_next.state = VSFS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= '{state: VSFS_IDLE, pwm: {PHASES{VSFS_PWM_MID}}, default: '0};
        end
        else if (clk_en_i)
        begin
            state_reg <= state_next;
        end
    end

    assign dac_code_o                   = state_reg.dac;
    assign pwm_state_o                  = state_reg.pwm;
    assign test_current_o               = state_reg.test_cur;
    assign driver_on_output_o           = state_reg.drv_on;
    assign regulator_ready_o            = state_reg.ready;
    assign current_limit_stages_armed_o = state_reg.armed;
    assign oc_fault_o                   = (state_reg.state == VSFS_OC_LATCH);
    assign ov_fault_o                   = (state_reg.state == VSFS_OV_LATCH);
endmodule // vsfs_sequencer

// File: test/vsfs_gate_model.sv
module vsfs_gate_model
    import vsfs_pkg::*;
#(
    parameter int PHASES      = 4,
    parameter int HOLD_CYCLES = 20
)
(
    input  wire logic                  clk_i,
    input  wire logic                  hold_req_i,
    input  wire vsfs_pwm_t [PHASES-1:0] pwm_state_i,
    input  wire logic                  driver_on_i,
    output logic                       driver_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold_cnt = 0;
    // A supply dip keeps the shared line low for a minimum time
    always @(posedge clk_i)
        if (hold_req_i)
            hold_cnt <= HOLD_CYCLES;
        else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
    assign driver_ready_o = (hold_cnt == 0) && !hold_req_i;
endmodule // vsfs_gate_model

// File: test/vsfs_seq_checker.sv
`include "vsfs_params.svh"

module vsfs_seq_checker
    import vsfs_pkg::*;
#(
    parameter int PHASES     = 4,
    parameter int DAC_W      = 8,
    parameter int OCP_CYCLES = 8
)
(
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  enable_i,
    input wire logic [DAC_W-1:0]      vout_code_i,
    input wire logic                  limit_threshold_current_i,
    input wire logic                  upper_overcurrent_i,
    input wire logic                  driver_ready_i,
    input wire logic [DAC_W-1:0]      dac_code_o,
    input wire vsfs_pwm_t [PHASES-1:0] pwm_state_o,
    input wire logic                  test_current_o,
    input wire logic                  driver_on_output_o,
    input wire logic                  regulator_ready_o,
    input wire logic                  current_limit_stages_armed_o,
    input wire logic                  oc_fault_o,
    input wire logic                  ov_fault_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    int oc_cnt_reg;
    // Counts only armed, unlatched cycles so a latched fault cannot keep it running
    always_ff @(posedge clk_i or posedge reset_i)
        if (reset_i)
            oc_cnt_reg <= 0;
        else if (enable_i && current_limit_stages_armed_o && limit_threshold_current_i
                 && !oc_fault_o && !ov_fault_o)
            oc_cnt_reg <= oc_cnt_reg + 1;
        else
            oc_cnt_reg <= 0;

    a_open_test: assert property (
        test_current_o |-> pwm_state_o[0] == VSFS_PWM_OPEN) else $error("pwm not open");
    a_mid_drv_on: assert property (
        $rose(driver_on_output_o) |-> $past(pwm_state_o[0]) == VSFS_PWM_MID)
        else $error("driver on before mid");
    a_drv_needs_ready: assert property (
        $rose(driver_on_output_o) |-> $past(driver_ready_i)) else $error("driver held low");
    a_disable_mid: assert property (
        !enable_i |=> pwm_state_o[0] == VSFS_PWM_MID && !driver_on_output_o)
        else $error("disable not mid");
    a_dac_step: assert property (
        $past(enable_i) && !ov_fault_o && !oc_fault_o && dac_code_o != $past(dac_code_o)
        |-> dac_code_o == $past(dac_code_o) + 1'b1) else $error("dac step wrong");
    a_arm_level: assert property (
        $rose(current_limit_stages_armed_o) |-> $past(vout_code_i) >= `VSFS_VOUT_ARM_CODE
        || $past(dac_code_o) >= `VSFS_ARM_DAC_CODE) else $error("armed too early");
    a_upper_oc: assert property (
        enable_i && current_limit_stages_armed_o && upper_overcurrent_i && !ov_fault_o
        |=> oc_fault_o) else $error("upper oc missed");
    a_oc_timer: assert property (
        oc_cnt_reg == OCP_CYCLES |-> ##[0:2] oc_fault_o) else $error("oc timer late");
    a_oc_latch: assert property (
        oc_fault_o && enable_i |=> oc_fault_o && !driver_on_output_o)
        else $error("oc latch lost");
    a_ov_latch: assert property (
        ov_fault_o && enable_i |=> ov_fault_o && !regulator_ready_o)
        else $error("ov latch lost");
    a_ov_no_high: assert property (
        ov_fault_o |-> pwm_state_o[0] != VSFS_PWM_HIGH) else $error("high side on in ov");
endmodule // vsfs_seq_checker

bind vsfs_sequencer vsfs_seq_checker #(.PHASES(PHASES), .DAC_W(DAC_W), .OCP_CYCLES(OCP_CYCLES))
    u_chk (.clk_i, .reset_i, .enable_i, .vout_code_i, .limit_threshold_current_i,
           .upper_overcurrent_i, .driver_ready_i, .dac_code_o, .pwm_state_o, .test_current_o,
           .driver_on_output_o, .regulator_ready_o, .current_limit_stages_armed_o,
           .oc_fault_o, .ov_fault_o);

// File: test/vsfs_sequencer_tb.sv
module vsfs_sequencer_tb;
    import vsfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PH = 4, CFG = 4, OCP = 8, STP = 2;
    logic clk_i = 0, reset_i = 1, enable_i = 0, limit_threshold_current_i = 0;
    logic upper_overcurrent_i = 0, hold_req = 0, track = 1, driver_ready_i;
    logic [7:0] target_code_i = 8'h40, vout_code_i = 8'h00, droop_code_i = 8'h00;
    logic [PH-1:0] pwm_request_i = '0;
    logic [7:0] dac_code_o;
    vsfs_pwm_t [PH-1:0] pwm_state_o;
    logic test_current_o, driver_on_output_o, regulator_ready_o;
    logic current_limit_stages_armed_o, oc_fault_o, ov_fault_o;
    int fail_count = 0, n_tests = 0;

    vsfs_sequencer #(.PHASES(PH), .DAC_W(8), .CFG_CYCLES(CFG), .OCP_CYCLES(OCP),
        .STEP_CYCLES(STP)) dut (.clk_i, .reset_i, .clk_en_i(1'b1), .enable_i, .target_code_i,
        .vout_code_i, .droop_code_i, .limit_threshold_current_i, .upper_overcurrent_i,
        .pwm_request_i, .driver_ready_i, .dac_code_o, .pwm_state_o, .test_current_o,
        .driver_on_output_o, .regulator_ready_o, .current_limit_stages_armed_o,
        .oc_fault_o, .ov_fault_o);
    vsfs_gate_model #(.PHASES(PH)) u_drv (.clk_i, .hold_req_i(hold_req),
        .pwm_state_i(pwm_state_o), .driver_on_i(driver_on_output_o),
        .driver_ready_o(driver_ready_i));

    always #5 clk_i = ~clk_i;
    // Output sense follows the DAC so no fault trips unless a test moves it
    // Lands in the edge's own update step so a test write just after it wins
    always @(posedge clk_i) if (track) vout_code_i <= dac_code_o;

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic start(bit hold);
        int k;
        enable_i = 0;
        track = 1;
        pwm_request_i = '0;
        target_code_i = 8'h20 + 8'($urandom_range(0, 8'h50));
        cyc(1);
        chk("dis_mid", VSFS_PWM_MID, pwm_state_o[PH-1]);
        hold_req = hold;
        enable_i = 1;
        cyc(1);
        chk("open", VSFS_PWM_OPEN, pwm_state_o[PH-1]);
        chk("test_cur", 1, test_current_o);
        cyc(CFG);
        chk("mid", VSFS_PWM_MID, pwm_state_o[0]);
        hold_req = 0;
        cyc(1);
        chk("drv_on", !hold, driver_on_output_o);
        if (!hold)
        begin
            cyc(2);
            pwm_request_i = 4'b0010;
            cyc(2);
            chk("ph1_left", 1, pwm_state_o[1] != VSFS_PWM_MID);
            chk("ph0_mid", VSFS_PWM_MID, pwm_state_o[0]);
        end
        for (k = 0; k < 2000 && !regulator_ready_o; k++)
            cyc(1);
        chk("dac_end", target_code_i, dac_code_o);
        if (!hold) chk("ramp_len", 1, k + 4 >= (target_code_i - 1) * STP && k <= (target_code_i + 2) * STP);
        chk("armed", 1, current_limit_stages_armed_o);
        pwm_request_i = 4'($urandom);
        $display("start hold=%0d done", hold);
    endtask

    initial
    begin
        #200us;
        fail_count++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(32'hbddf));
        cyc(6);
        reset_i = 0;
        start(1);
        start(0);
        limit_threshold_current_i = 1;
        cyc(OCP - 2);
        limit_threshold_current_i = 0;
        cyc(1);
        chk("oc_short", 0, oc_fault_o);
        limit_threshold_current_i = 1;
        cyc(OCP + 3);
        limit_threshold_current_i = 0;
        cyc(5);
        chk("oc_long", 1, oc_fault_o);
        chk("oc_drv", 0, driver_on_output_o);
        $display("test timer done");
        start(0);
        upper_overcurrent_i = 1;
        cyc(1);
        upper_overcurrent_i = 0;
        cyc(1);
        chk("oc_upper", 1, oc_fault_o);
        $display("test upper done");
        start(0);
        track = 0;
        droop_code_i = 8'($urandom_range(0, 7));
        vout_code_i = dac_code_o - droop_code_i - 8'h10;
        cyc(3);
        chk("uv_ready", 0, regulator_ready_o);
        $display("test uv done");
        start(0);
        droop_code_i = 8'h00;
        track = 0;
        vout_code_i = dac_code_o + 8'h15;
        cyc(2);
        chk("ov", 1, ov_fault_o);
        chk("ov_low", VSFS_PWM_LOW, pwm_state_o[0]);
        cyc(3 * STP);
        chk("ov_ramp", 1, dac_code_o < target_code_i);
        vout_code_i = 8'h00;
        cyc(3);
        chk("ov_mid", VSFS_PWM_MID, pwm_state_o[0]);
        chk("ov_hold", 1, ov_fault_o);
        $display("test ov done");
        enable_i = 0;
        cyc(1);
        enable_i = 1;
        vout_code_i = 8'h90;
        // Config, driver wait, then a few ramp cycles where the absolute level applies
        cyc(CFG + 4);
        chk("abs_low", 0, ov_fault_o);
        vout_code_i = 8'h92;
        cyc(2);
        chk("abs_trip", 1, ov_fault_o);
        $display("test abs done");
        give_verdict();
    end
endmodule // vsfs_sequencer_tb
